//--- ncc_pkg.sv
// constants shared by the nand command controller files
// assumes a 200 MHz clock and a 32-bit apb register port
package ncc_pkg;
  // apb word offsets
  localparam logic [7:0] OFF_ISSUE = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_PAGE = 8'h08;
  localparam logic [7:0] OFF_CONF = 8'h0c;
  localparam logic [7:0] OFF_BAD = 8'h10;
  // issue, bad, conf and stat register field positions
  localparam int ISS_KIND_LSB = 8;
  localparam int BAD_MARK_BIT = 16;
  localparam int CONF_PROT_BIT = 0;
  localparam int STAT_REFUSED_BIT = 3;
  // cycle kinds
  typedef enum logic [1:0] {
    NCC_CMD = 2'h0,
    NCC_ADDR = 2'h1,
    NCC_WDATA = 2'h2,
    NCC_RDATA = 2'h3
  } ncc_kind_t;
  // device command codes
  localparam logic [7:0] C_READ = 8'h00;
  localparam logic [7:0] C_READ_GO = 8'h30;
  localparam logic [7:0] C_RCOL = 8'h05;
  localparam logic [7:0] C_RCOL_GO = 8'he0;
  localparam logic [7:0] C_SERIAL = 8'h80;
  localparam logic [7:0] C_COLCHG = 8'h85;
  localparam logic [7:0] C_PROG = 8'h10;
  localparam logic [7:0] C_MPROG = 8'h11;
  localparam logic [7:0] C_ERASE = 8'h60;
  localparam logic [7:0] C_ERASE_GO = 8'hd0;
  localparam logic [7:0] C_STATUS = 8'h70;
  localparam logic [7:0] C_ALTSTAT = 8'h71;
  localparam logic [7:0] C_ID = 8'h90;
  localparam logic [7:0] C_RESET = 8'hff;
  // ecc status byte codes
  localparam logic [3:0] ECC_MAX_FIX = 4'h8;
  localparam logic [3:0] ECC_UNCORR = 4'hf;
  localparam logic [3:0] ECC_LAST_SECTOR = 4'h3;
  // array geometry
  localparam int BLOCKS = 2048;
  localparam logic [2:0] PART_PROG_MAX = 3'h4;
  localparam logic [9:0] SECTOR_BYTES = 10'd528;
  // strobe timing
  localparam int CLK_MHZ = 200;
  localparam int T_SETUP_NS = 10;
  localparam int T_PULSE_NS = 25;
  localparam int T_HOLD_NS = 10;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
endpackage

//--- ncc_ecc_dec.sv
// splits an ecc status byte into count, failure and sector
// assumes the byte was read right after the ecc status command
`timescale 1ns/1ps
module ncc_ecc_dec (
  // status byte
  input wire logic [7:0] byte_in,
  // decoded view
  output logic [3:0] fixed_out,
  output logic uncorr_out,
  output logic [1:0] sector_out,
  output logic reserved_out
);
  assign fixed_out = (byte_in[3:0] <= ncc_pkg::ECC_MAX_FIX) ?
                     byte_in[3:0] : 4'h0;
  assign uncorr_out = (byte_in[3:0] == ncc_pkg::ECC_UNCORR);
  assign sector_out = byte_in[5:4];
  assign reserved_out = (byte_in[7:4] > ncc_pkg::ECC_LAST_SECTOR);
endmodule

//--- ncc_cycle.sv
// drives one command, address or data cycle on the nand pins
// assumes start only when idle; one cycle at a time
`timescale 1ns/1ps
module ncc_cycle (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // request
  input wire logic start_in,
  input wire ncc_pkg::ncc_kind_t kind_in,
  input wire logic [7:0] byte_in,
  // answer
  output logic busy_out,
  output logic [7:0] rdata_out,
  // pins
  output logic ce_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic read_strobe_n_out,
  output logic [7:0] io_out,
  output logic io_oe_out,
  input wire logic [7:0] io_in
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SETUP = 2'b01,
    S_PULSE = 2'b11,
    S_HOLD = 2'b10
  } ncc_cyc_t;
  ncc_cyc_t st_ff;
  logic [3:0] cnt_ff;
  ncc_pkg::ncc_kind_t kind_ff;
  wire last = (cnt_ff == 4'h1);
  wire is_rd = (kind_ff == ncc_pkg::NCC_RDATA);
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      st_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      kind_ff <= ncc_pkg::NCC_CMD;
      busy_out <= 1'b0;
      rdata_out <= 8'h00;
      ce_n_out <= 1'b1;
      cle_out <= 1'b0;
      ale_out <= 1'b0;
      we_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      io_out <= 8'h00;
      io_oe_out <= 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff - 4'h1;
      unique case (st_ff)
        S_IDLE:
        begin
          if (start_in)
          begin
            st_ff <= S_SETUP;
            cnt_ff <= ncc_pkg::SETUP_CYC;
            kind_ff <= kind_in;
            busy_out <= 1'b1;
            ce_n_out <= 1'b0;
            cle_out <= (kind_in == ncc_pkg::NCC_CMD);
            ale_out <= (kind_in == ncc_pkg::NCC_ADDR);
            io_out <= byte_in;
            io_oe_out <= (kind_in != ncc_pkg::NCC_RDATA);
          end
        end
        S_SETUP:
        begin
          if (last)
          begin
            st_ff <= S_PULSE;
            cnt_ff <= ncc_pkg::PULSE_CYC;
            we_n_out <= is_rd;
            read_strobe_n_out <= !is_rd;
          end
        end
        S_PULSE:
        begin
          if (last)
          begin
            st_ff <= S_HOLD;
            cnt_ff <= ncc_pkg::HOLD_CYC;
            we_n_out <= 1'b1;
            read_strobe_n_out <= 1'b1;
            if (is_rd)
              rdata_out <= io_in;
          end
        end
        S_HOLD:
        begin
          if (last)
          begin
            st_ff <= S_IDLE;
            busy_out <= 1'b0;
            cle_out <= 1'b0;
            ale_out <= 1'b0;
            io_oe_out <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule

//--- ncc_host.sv
// nand host controller: apb registers, command filter, pin cycles
// assumes apb master in the same clock domain; nand pins synchronous
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module ncc_host (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // nand pins
  output logic ce_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic read_strobe_n_out,
  output logic wp_n_out,
  output logic [7:0] io_out,
  output logic io_oe_out,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_output_in
);
  logic eng_busy;
  logic [7:0] rd_byte;
  logic start_ff;
  ncc_pkg::ncc_kind_t kind_ff;
  logic [7:0] byte_ff;
  logic init_done_ff;
  logic serial_ff;
  logic refused_ff;
  logic prot_ff;
  logic [10:0] blk_ff;
  logic [5:0] page_ff;
  logic [10:0] last_blk_ff;
  logic [5:0] last_page_ff;
  logic trk_ff;
  logic [2:0] pp_cnt_ff;
  logic [9:0] sect_ff;
  logic bad_mem [0:ncc_pkg::BLOCKS-1];

  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = c inside {ncc_pkg::C_READ, ncc_pkg::C_READ_GO,
      ncc_pkg::C_RCOL, ncc_pkg::C_RCOL_GO, ncc_pkg::C_SERIAL,
      ncc_pkg::C_COLCHG, ncc_pkg::C_PROG, ncc_pkg::C_MPROG,
      ncc_pkg::C_ERASE, ncc_pkg::C_ERASE_GO, ncc_pkg::C_STATUS,
      ncc_pkg::C_ALTSTAT, ncc_pkg::C_ID, ncc_pkg::C_RESET};
  endfunction

  function automatic logic is_confirm(input logic [7:0] c);
    is_confirm = (c == ncc_pkg::C_PROG) || (c == ncc_pkg::C_MPROG);
  endfunction

  // apb decode; writes land on the edge that sees pready high
  wire acc = psel_in && penable_in;
  wire wr_go = acc && pwrite_in && pready_out;
  wire hit_issue = (paddr_in == ncc_pkg::OFF_ISSUE);
  wire hit_stat = (paddr_in == ncc_pkg::OFF_STAT);
  wire hit_page = (paddr_in == ncc_pkg::OFF_PAGE);
  wire hit_conf = (paddr_in == ncc_pkg::OFF_CONF);
  wire hit_bad = (paddr_in == ncc_pkg::OFF_BAD);
  wire mapped = hit_issue | hit_stat | hit_page | hit_conf | hit_bad;

  // requested cycle
  wire [7:0] req_byte = pwdata_in[7:0];
  wire [1:0] req_kind = pwdata_in[ncc_pkg::ISS_KIND_LSB +: 2];
  wire req_cmd = (req_kind == 2'(ncc_pkg::NCC_CMD));
  wire req_data = (req_kind == 2'(ncc_pkg::NCC_WDATA));
  wire issue = wr_go && hit_issue;
  wire idle = !eng_busy && !start_ff;
  wire rb = ready_busy_output_in;

  wire ok_known = cmd_known(req_byte);
  wire ok_init = init_done_ff || (req_byte == ncc_pkg::C_RESET) ||
                 (req_byte == ncc_pkg::C_STATUS);
  wire ok_busy = rb || req_byte inside {ncc_pkg::C_STATUS,
                 ncc_pkg::C_ALTSTAT, ncc_pkg::C_RESET};
  wire ok_serial = !serial_ff || req_byte inside {ncc_pkg::C_COLCHG,
                   ncc_pkg::C_PROG, ncc_pkg::C_MPROG, ncc_pkg::C_RESET};
  wire same_blk = trk_ff && (blk_ff == last_blk_ff);
  wire same_page = same_blk && (page_ff == last_page_ff);
  wire ok_order = !is_confirm(req_byte) || !same_blk ||
                  (page_ff >= last_page_ff);
  wire ok_part = !is_confirm(req_byte) || !same_page ||
                 (pp_cnt_ff < ncc_pkg::PART_PROG_MAX);
  wire ok_sect = !is_confirm(req_byte) || (sect_ff == 10'h000);
  wire ok_bad = (req_byte != ncc_pkg::C_ERASE_GO) || !bad_mem[blk_ff];
  wire legal = !req_cmd || (ok_known && ok_init && ok_busy &&
               ok_serial && ok_order && ok_part && ok_sect && ok_bad);
  wire take = issue && idle && legal;
  wire refuse = issue && !(idle && legal);
  wire clr_ref = wr_go && hit_stat && pwdata_in[ncc_pkg::STAT_REFUSED_BIT];

  wire s_cmd = start_ff && (kind_ff == ncc_pkg::NCC_CMD);
  wire s_conf = s_cmd && is_confirm(byte_ff);
  wire s_wdata = start_ff && (kind_ff == ncc_pkg::NCC_WDATA);

  logic [3:0] ecc_fixed;
  logic ecc_uncorr;
  logic [1:0] ecc_sector;
  logic ecc_resv;
  wire [31:0] stat_word = {8'h00, ecc_resv, ecc_sector, ecc_uncorr,
    ecc_fixed, rd_byte, 3'h0, serial_ff, refused_ff, init_done_ff,
    rb, eng_busy};
  wire [31:0] rd_mux = hit_stat ? stat_word :
    hit_page ? {15'h0000, blk_ff, page_ff} :
    hit_conf ? {31'h00000000, prot_ff} : 32'h00000000;

  // apb answer one cycle into the access phase
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end
    else
    begin
      pready_out <= acc && !pready_out;
      pslverr_out <= acc && !pready_out && !mapped;
      prdata_out <= rd_mux;
    end
  end

  // software state
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      start_ff <= 1'b0;
      kind_ff <= ncc_pkg::NCC_CMD;
      byte_ff <= 8'h00;
      refused_ff <= 1'b0;
      prot_ff <= 1'b1;
      wp_n_out <= 1'b0;
      blk_ff <= 11'h000;
      page_ff <= 6'h00;
      init_done_ff <= 1'b0;
    end
    else
    begin
      start_ff <= take;
      if (take)
      begin
        kind_ff <= ncc_pkg::ncc_kind_t'(req_kind);
        byte_ff <= req_byte;
      end
      // set wins over a same-cycle clear
      refused_ff <= refuse || (refused_ff && !clr_ref);
      if (wr_go && hit_conf)
        prot_ff <= pwdata_in[ncc_pkg::CONF_PROT_BIT];
      wp_n_out <= !prot_ff;
      if (wr_go && hit_page)
      begin
        blk_ff <= pwdata_in[16:6];
        page_ff <= pwdata_in[5:0];
      end
      if (rb)
        init_done_ff <= 1'b1;
    end
  end

  // program tracking
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      serial_ff <= 1'b0;
      trk_ff <= 1'b0;
      last_blk_ff <= 11'h000;
      last_page_ff <= 6'h00;
      pp_cnt_ff <= 3'h0;
      sect_ff <= 10'h000;
    end
    else
    begin
      if (s_cmd)
        serial_ff <= (byte_ff == ncc_pkg::C_SERIAL) ||
                     (serial_ff && byte_ff == ncc_pkg::C_COLCHG);
      if (s_cmd && byte_ff == ncc_pkg::C_SERIAL)
        sect_ff <= 10'h000;
      else if (s_wdata)
        sect_ff <= (sect_ff == ncc_pkg::SECTOR_BYTES - 10'd1) ?
                   10'h000 : sect_ff + 10'd1;
      if (s_conf)
      begin
        trk_ff <= 1'b1;
        last_blk_ff <= blk_ff;
        last_page_ff <= page_ff;
        pp_cnt_ff <= same_page ? pp_cnt_ff + 3'h1 : 3'h1;
      end
      else if (s_cmd && byte_ff == ncc_pkg::C_ERASE_GO && same_blk)
        trk_ff <= 1'b0;
    end
  end

  // bad block map, one bit per block
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < ncc_pkg::BLOCKS; i++)
        bad_mem[i] <= 1'b0;
    end
    else if (wr_go && hit_bad)
      bad_mem[pwdata_in[10:0]] <= pwdata_in[ncc_pkg::BAD_MARK_BIT];
  end

  ncc_cycle u_cycle (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(start_ff),
    .kind_in(kind_ff),
    .byte_in(byte_ff),
    .busy_out(eng_busy),
    .rdata_out(rd_byte),
    .ce_n_out(ce_n_out),
    .cle_out(cle_out),
    .ale_out(ale_out),
    .we_n_out(we_n_out),
    .read_strobe_n_out(read_strobe_n_out),
    .io_out(io_out),
    .io_oe_out(io_oe_out),
    .io_in(io_in)
  );

  ncc_ecc_dec u_dec (
    .byte_in(rd_byte),
    .fixed_out(ecc_fixed),
    .uncorr_out(ecc_uncorr),
    .sector_out(ecc_sector),
    .reserved_out(ecc_resv)
  );

  sequence s_cmd_sent;
    start_ff && kind_ff == ncc_pkg::NCC_CMD;
  endsequence
  sequence s_cmd_strobe;
    ##[1:40] (cle_out && !we_n_out);
  endsequence

  property p_init_cmds;
    @(posedge clock_in) disable iff (rst_in)
    s_cmd_sent and !init_done_ff |->
      byte_ff == ncc_pkg::C_RESET || byte_ff == ncc_pkg::C_STATUS;
  endproperty
  a_init_cmds: assert property (p_init_cmds)
    else $error("non reset/status command during init");

  property p_known;
    @(posedge clock_in) disable iff (rst_in)
    s_cmd_sent |-> cmd_known(byte_ff) ##0 s_cmd_strobe;
  endproperty
  a_known: assert property (p_known)
    else $error("unknown command or no strobe");

  property p_busy_cmds;
    @(posedge clock_in) disable iff (rst_in)
    s_cmd_sent and !$past(ready_busy_output_in) |->
      byte_ff inside {ncc_pkg::C_STATUS, ncc_pkg::C_ALTSTAT,
                      ncc_pkg::C_RESET};
  endproperty
  a_busy_cmds: assert property (p_busy_cmds)
    else $error("forbidden command while busy");

  property p_after_serial;
    @(posedge clock_in) disable iff (rst_in)
    s_cmd_sent and serial_ff |->
      byte_ff inside {ncc_pkg::C_COLCHG, ncc_pkg::C_PROG,
                      ncc_pkg::C_MPROG, ncc_pkg::C_RESET};
  endproperty
  a_after_serial: assert property (p_after_serial)
    else $error("bad command after serial input");

  property p_page_order;
    @(posedge clock_in) disable iff (rst_in)
    s_conf && trk_ff && blk_ff == last_blk_ff |->
      page_ff >= last_page_ff ##1 last_page_ff == $past(page_ff);
  endproperty
  a_page_order: assert property (p_page_order)
    else $error("page programmed out of order");

  property p_sector;
    @(posedge clock_in) disable iff (rst_in)
    s_conf |-> sect_ff == 10'h000;
  endproperty
  a_sector: assert property (p_sector)
    else $error("program confirm inside a sector");

  property p_partial;
    @(posedge clock_in) disable iff (rst_in)
    s_conf |=> pp_cnt_ff <= ncc_pkg::PART_PROG_MAX && pp_cnt_ff != 3'h0;
  endproperty
  a_partial: assert property (p_partial)
    else $error("page programmed more than four times");

  property p_bad_erase;
    @(posedge clock_in) disable iff (rst_in)
    s_cmd_sent and byte_ff == ncc_pkg::C_ERASE_GO |-> !bad_mem[blk_ff];
  endproperty
  a_bad_erase: assert property (p_bad_erase)
    else $error("erase sent to a bad block");
endmodule

//--- ncc_nand_model.sv
// nand device model: command latch, status byte and busy timing
// assumes pins from ncc_host; the bench resolves the io bus
`timescale 1ns/1ps
module ncc_nand_model #(
  parameter int INIT_NS = 1000,
  parameter int BUSY_NS = 400
) (
  // control pins
  input wire logic ce_n_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic read_strobe_n_in,
  input wire logic wp_n_in,
  // data
  input wire logic [7:0] io_in,
  input wire logic [7:0] ecc_in,
  output logic [7:0] io_out,
  output logic ready_busy_output_out
);
  realtime busy_end = INIT_NS;
  logic stat_mode = 1'b0;
  logic fail = 1'b0;
  logic prog = 1'b0;
  logic drive = 1'b0;
  logic [7:0] last = 8'h00;
  logic [3:0] addr_cnt = 4'h0;
  always
  begin
    ready_busy_output_out = ($realtime >= busy_end);
    #1;
  end
  always @(posedge we_n_in)
  begin
    if (!ce_n_in && cle_in)
    begin
      addr_cnt = 4'h0;
      case (io_in)
        8'hff: busy_end = $realtime + 20.0;
        8'h70, 8'h71: stat_mode = 1'b1;
        8'h00: stat_mode = 1'b0;
        8'h30: busy_end = $realtime + BUSY_NS;
        // only protect fails; no worn blocks
        8'h10, 8'h11, 8'hd0:
          if (wp_n_in)
          begin
            busy_end = $realtime + BUSY_NS;
            prog = 1'b1;
          end
          else
            fail = 1'b1;
        default: ;
      endcase
    end
    else if (!ce_n_in && ale_in && addr_cnt < 4'h6)
      addr_cnt = addr_cnt + 4'h1;
  end
  // protect low cuts a running write
  always @(negedge wp_n_in)
    if (prog)
      busy_end = $realtime;
  // status or ecc byte per strobe
  always @(negedge read_strobe_n_in)
  begin
    last = stat_mode ? {wp_n_in, {2{ready_busy_output_out}}, 4'h0, fail}
                     : ecc_in;
    drive = 1'b1;
  end
  always @(posedge read_strobe_n_in)
    drive <= #3 1'b0;
  // released bus shows the inverse, not a stale byte
  assign io_out = drive ? last : ~last;
endmodule

//--- tb_ncc_host.sv
// self-checking bench for the nand host controller
// assumes ncc_nand_model on the pins and an apb master here
`timescale 1ns/1ps
module tb_ncc_host;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
    logic er;
    bit chk;
  } ncc_note_t;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, b, ecc = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, e;
  logic pready, pslverr, ce_n, cle, ale, we_n, wp_n, io_oe, rb;
  logic read_strobe_n;
  logic [7:0] io_o, io_i, dev_io;
  ncc_note_t notes[$];
  ncc_note_t n;
  int bad_count = 0, compares = 0, cyc = 0;
  integer seed = 32'hb977;
  always #2.5 clock_in = ~clock_in;
  assign io_i = io_oe ? io_o : dev_io;
  ncc_host dut_u (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .ce_n_out(ce_n), .cle_out(cle), .ale_out(ale),
    .we_n_out(we_n), .read_strobe_n_out(read_strobe_n), .wp_n_out(wp_n),
    .io_out(io_o), .io_oe_out(io_oe), .io_in(io_i),
    .ready_busy_output_in(rb));
  ncc_nand_model dev_u (.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale),
    .we_n_in(we_n), .read_strobe_n_in(read_strobe_n), .wp_n_in(wp_n),
    .io_in(io_i),
    .ecc_in(ecc), .io_out(dev_io), .ready_busy_output_out(rb));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                        input logic [31:0] m, input logic er);
    notes.push_back('{x, m, er, 1'b1});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rd_raw(input logic [7:0] a);
    notes.push_back('{32'h0, 32'h0, 1'b0, 1'b0});
    apb(1'b0, a, 32'h0);
  endtask
  // waits on the engine busy flag, not on a fixed count
  task automatic issue(input logic [1:0] k, input logic [7:0] d);
    apb(1'b1, 8'h00, {22'h0, k, d});
    do rd_raw(8'h04); while (rd[0] !== 1'b0);
  endtask
  task automatic cmd(input logic [7:0] d);
    issue(2'h0, d);
  endtask
  task automatic refused(input logic r);
    rd_chk(8'h04, {28'h0, r, 3'h0}, 32'h8, 1'b0);
    apb(1'b1, 8'h04, 32'h8);
  endtask
  task automatic wait_rdy();
    do rd_raw(8'h04); while (rd[1] !== 1'b1);
  endtask
  task automatic prog(input logic r);
    cmd(8'h80);
    cmd(8'h10);
    refused(r);
    if (r)
      cmd(8'hff);
    wait_rdy();
  endtask
  // monitor: oldest note against each completed read
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite && notes.size() > 0)
    begin
      n = notes.pop_front();
      if (n.chk)
      begin
        check(prdata & n.m, n.e);
        check({31'h0, pslverr}, {31'h0, n.er});
      end
    end
  end
  initial
  begin
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    rd_chk(8'h0c, 32'h1, 32'h1, 1'b0);
    check({31'h0, wp_n}, 32'h0);
    rd_chk(8'h04, 32'h0, 32'h6, 1'b0);
    cmd(8'h00);
    refused(1'b1);
    cmd(8'h70);
    refused(1'b0);
    wait_rdy();
    rd_chk(8'h04, 32'h6, 32'h6, 1'b0);
    cmd(8'h42);
    refused(1'b1);
    rd_chk(8'h20, 32'h0, 32'hffffffff, 1'b1);
    cmd(8'h00);
    // six address cycles; the device counts all six
    repeat (6)
      issue(2'h1, 8'($random(seed)));
    check({28'h0, dev_u.addr_cnt}, 32'h6);
    cmd(8'h30);
    cmd(8'h80);
    refused(1'b1);
    cmd(8'h71);
    refused(1'b0);
    wait_rdy();
    cmd(8'h70);
    repeat (2)
    begin
      issue(2'h3, 8'h00);
      rd_chk(8'h04, 32'h6000, 32'hff00, 1'b0);
    end
    // boundary codes first, then random reports
    cmd(8'h00);
    for (int i = 0; i < 12; i++)
    begin
      b = (i == 0) ? 8'h08 : (i == 1) ? 8'hc9 : 8'($random(seed));
      e = {8'h0, (b[7:6] != 2'h0), b[5:4], (b[3:0] == 4'hf),
           ((b[3:0] > 4'h8) ? 4'h0 : b[3:0]), b, 8'h0};
      ecc <= b;
      issue(2'h3, 8'h00);
      rd_chk(8'h04, e, 32'hffff00, 1'b0);
    end
    apb(1'b1, 8'h0c, 32'h0);
    repeat (2) @(posedge clock_in);
    check({31'h0, wp_n}, 32'h1);
    apb(1'b1, 8'h08, 32'h85);
    prog(1'b0);
    apb(1'b1, 8'h08, 32'h83);
    prog(1'b1);
    apb(1'b1, 8'h08, 32'h88);
    for (int i = 0; i < 5; i++)
      prog(i == 4);
    apb(1'b1, 8'h08, 32'h89);
    cmd(8'h80);
    issue(2'h2, 8'ha5);
    cmd(8'h10);
    refused(1'b1);
    cmd(8'hff);
    cmd(8'h80);
    cmd(8'h00);
    refused(1'b1);
    cmd(8'h85);
    refused(1'b0);
    cmd(8'hff);
    wait_rdy();
    cmd(8'h70);
    issue(2'h3, 8'h00);
    rd_chk(8'h04, 32'he000, 32'hff00, 1'b0);
    apb(1'b1, 8'h10, 32'h10009);
    apb(1'b1, 8'h08, 32'h240);
    cmd(8'h60);
    cmd(8'hd0);
    refused(1'b1);
    cmd(8'hff);
    finish_test();
  end
  // hang guard
  always @(posedge clock_in)
    if (cyc > 20000)
    begin
      bad_count++;
      finish_test();
    end
endmodule
